/* bench/duhmp_bench.sv */
// self-checking bench for the host pin and modem line block
module duhmp_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import duhmp_pkg::*;
	typedef struct packed {int ch; logic wr; logic [2:0] a; logic [7:0] wd, m, e;} duhmp_row_type;
	logic clk = 0, reset = 1, clkEn = 1, hostDrv = 0, readyA = 0, readyB = 1;
	logic chanASelect_n = 1, chanBSelect_n = 1, readStrobe_n = 1, writeStrobe_n = 1;
	logic [2:0] regAddr = 0;
	logic [7:0] hostData = 0, txChar = 0, dataBusIn, dataBusOut, txShiftBits, d;
	logic dataBusOe, terminalReadyA_n, terminalReadyB_n, clearToSendA_n, clearToSendB_n;
	logic txAllowedA, txAllowedB, rs485DriveA, rs485DriveB;
	int error_cnt = 0, samples_checked = 0, cycles = 0;
	duhmp_row_type rows [6] = '{'{0, 1, ADDR_MODEM_CONTROL, 8'h01, 8'hff, 8'h01},
		'{1, 1, ADDR_SCRATCH, 8'ha5, 8'hff, 8'ha5}, '{0, 1, ADDR_SCRATCH, 8'h5a, 8'hff, 8'h5a},
		'{0, 1, 3'h5, 8'hff, 8'hff, 8'h00}, '{0, 0, ADDR_MODEM_STATUS, 8'h00, 8'h10, 8'h00},
		'{0, 1, ADDR_MODEM_CONTROL, 8'h00, 8'hff, 8'h00}};
	always #4 clk = ~clk;
	// undriven bus shows the inverse of the last host value, never a kind guess
	assign dataBusIn = dataBusOe ? dataBusOut : (hostDrv ? hostData : ~hostData);
	duhmp_top i_dut (.*);
	duhmp_modem i_modemA (.clk(clk), .readyToAccept(readyA), .terminalReady_n(terminalReadyA_n),
		.clearToSend_n(clearToSendA_n), .driverOn());
	duhmp_modem i_modemB (.clk(clk), .readyToAccept(readyB), .terminalReady_n(terminalReadyB_n),
		.clearToSend_n(clearToSendB_n), .driverOn());
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// strobes held long enough for the sync flops, then idle gap
	task automatic busWrite(input int ch, input logic [2:0] a, input logic [7:0] wd);
		regAddr = a; hostData = wd; hostDrv = 1;
		chanASelect_n = (ch != 0); chanBSelect_n = (ch != 1);
		step(1); writeStrobe_n = 0; step(5); writeStrobe_n = 1; step(3);
		chanASelect_n = 1; chanBSelect_n = 1; hostDrv = 0; step(3);
	endtask
	task automatic busRead(input int ch, input logic [2:0] a, output logic [7:0] rd);
		int n;
		n = 0; regAddr = a;
		chanASelect_n = (ch != 0); chanBSelect_n = (ch != 1); readStrobe_n = 0;
		while (dataBusOe !== 1'b1 && n < 10) begin
			step(1); n++;
		end
		rd = dataBusOut; readStrobe_n = 1; chanASelect_n = 1; chanBSelect_n = 1; step(4);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// hang guard well above the expected two hundred or so cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end
	// ************************************************************
	// main sequence: table rows, then the awkward cases
	// ************************************************************
	initial begin
		step(16); reset = 0; step(2);
		foreach (rows[i]) begin
			if (rows[i].wr) busWrite(rows[i].ch, rows[i].a, rows[i].wd);
			busRead(rows[i].ch, rows[i].a, d);
			check(d & rows[i].m, rows[i].e);
		end
		check({7'h00, terminalReadyA_n}, 8'h01);
		busWrite(0, ADDR_MODEM_CONTROL, 8'h01);
		check({7'h00, terminalReadyA_n}, 8'h00);
		check({7'h00, terminalReadyB_n}, 8'h01);
		busWrite(2, ADDR_MODEM_CONTROL, 8'h00);
		check({7'h00, terminalReadyA_n}, 8'h00);
		readyA = 1; step(4); busRead(0, ADDR_MODEM_STATUS, d);
		check(d & 8'h10, 8'h10);
		busWrite(0, ADDR_ENHANCED_FEATURE, 8'h80); readyA = 0; step(6);
		check({7'h00, txAllowedA}, 8'h00);
		readyA = 1; step(6);
		check({7'h00, txAllowedA}, 8'h01);
		busWrite(0, ADDR_ENHANCED_FEATURE, 8'h20); step(2);
		check({7'h00, rs485DriveA}, 8'h01);
		check({6'h00, txAllowedB, rs485DriveB}, 8'h02);
		txChar = 8'h01; step(2);
		check(txShiftBits, 8'h01);
		reset = 1; step(2);
		check({6'h00, terminalReadyA_n, dataBusOe}, 8'h02);
		reset = 0; step(2);
		wrap_up();
	end
endmodule // duhmp_bench
bind duhmp_top duhmp_sva i_sva (.*);

/* bench/duhmp_modem.sv */
// modem partner: answers clear-to-send, follows terminal ready
module duhmp_modem (
	input wire logic clk,
	input wire logic readyToAccept,
	input wire logic terminalReady_n,
	output logic clearToSend_n,
	output logic driverOn
);
	timeunit 1ns;
	timeprecision 1ps;
	// pin changes just after the edge, like a real line
	always_ff @(posedge clk) clearToSend_n <= #1 ~readyToAccept;
	// terminal ready low keys the line driver
	assign driverOn = ~terminalReady_n;
endmodule // duhmp_modem

/* bench/duhmp_sva.sv */
// port timing checker for the host pin and modem line block
module duhmp_sva (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic chanASelect_n,
	input wire logic chanBSelect_n,
	input wire logic readStrobe_n,
	input wire logic writeStrobe_n,
	input wire logic dataBusOe,
	input wire logic clearToSendA_n,
	input wire logic terminalReadyA_n,
	input wire logic terminalReadyB_n,
	input wire logic [7:0] txChar,
	input wire logic [7:0] txShiftBits,
	input wire logic txAllowedA,
	input wire logic rs485DriveA
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// five edges covers the two sync flops, the read pending register and the output register
	sequence readHeld;
		(clkEn && !readStrobe_n && !(chanASelect_n && chanBSelect_n))[*5];
	endsequence
	sequence busQuiet;
		(clkEn && readStrobe_n)[*4];
	endsequence
	read_drive_a: assert property (readHeld |-> dataBusOe) else $error("bus not driven in read");
	quiet_float_a: assert property (busQuiet |-> !dataBusOe) else $error("bus driven outside read");
	nosel_float_a: assert property ((clkEn && chanASelect_n && chanBSelect_n)[*4] |-> !dataBusOe)
		else $error("bus driven with no select");
	dtr_reset_a: assert property ($fell(reset) |-> terminalReadyA_n && terminalReadyB_n)
		else $error("terminal ready low after reset");
	dtr_hold_a: assert property ((clkEn && writeStrobe_n)[*8] |=> $stable(terminalReadyA_n))
		else $error("terminal ready moved without write");
	cts_gate_a: assert property ((clkEn && !clearToSendA_n)[*4] |-> txAllowedA)
		else $error("transmit blocked while clear");
	rs485_dtr_a: assert property ($rose(rs485DriveA) |-> ##[0:2] !terminalReadyA_n)
		else $error("driver enable without terminal ready");
	tx_order_a: assert property (clkEn |=> txShiftBits == $past(txChar)) else $error("shift copy wrong");
endmodule // duhmp_sva

/* rtl/duhmp_chan_regs.sv */
// per-channel register set: modem control, enhanced feature, scratch, status
module duhmp_chan_regs
	import duhmp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	// write port
	input wire logic writePulse,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] writeData,
	// synchronised modem input
	input wire logic clearToSendSync,
	// read port, registered
	output logic [7:0] readData_reg,
	output logic [7:0] modemControl_reg,
	output logic [7:0] enhancedFeature_reg
);
	logic [7:0] scratch_reg;
	logic [7:0] readData_next;

	// register writes; reset leaves terminal ready inactive
	always_ff @(posedge clk) begin
		if (reset) begin
			modemControl_reg <= MCR_RESET;
			enhancedFeature_reg <= EFR_RESET;
			scratch_reg <= SCRATCH_RESET;
		end else if (clkEn && writePulse) begin
			unique case (regAddr)
				ADDR_MODEM_CONTROL: modemControl_reg <= writeData;
				ADDR_ENHANCED_FEATURE: enhancedFeature_reg <= writeData;
				ADDR_SCRATCH: scratch_reg <= writeData;
				default: ;
			endcase
		end
	end

	// read multiplexer; status bit is the inverted pin (low pin reads as one)
	always_comb begin
		readData_next = 8'h00;
		unique case (regAddr)
			ADDR_MODEM_CONTROL: readData_next = modemControl_reg;
			ADDR_ENHANCED_FEATURE: readData_next = enhancedFeature_reg;
			ADDR_SCRATCH: readData_next = scratch_reg;
			ADDR_MODEM_STATUS: readData_next[MSR_CLEAR_TO_SEND_BIT] = ~clearToSendSync;
			default: readData_next = 8'h00;
		endcase
	end

	// registered read data, tracked continuously
	always_ff @(posedge clk) begin
		if (reset) begin
			readData_reg <= 8'h00;
		end else if (clkEn) begin
			readData_reg <= readData_next;
		end
	end
endmodule // duhmp_chan_regs

/* rtl/duhmp_pkg.sv */
// package of constants for the dual uart host pin and modem line block
package duhmp_pkg;
	// ************************************************************
	// register address map within one channel
	// ************************************************************
	localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
	localparam logic [2:0] ADDR_ENHANCED_FEATURE = 3'h2;
	localparam logic [2:0] ADDR_SCRATCH = 3'h7;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int MCR_TERMINAL_READY_BIT = 0;
	localparam int MSR_CLEAR_TO_SEND_BIT = 4;
	localparam int EFR_AUTO_CTS_BIT = 7;
	localparam int EFR_RS485_BIT = 5;
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] MCR_RESET = 8'h00;
	localparam logic [7:0] EFR_RESET = 8'h00;
	localparam logic [7:0] SCRATCH_RESET = 8'h00;
	localparam int NUM_CHANNELS = 2;
	// host access phases
	typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE} duhmp_access_type;
endpackage

/* rtl/duhmp_top.sv */
// top of the dual uart host bus pins and modem lines
module duhmp_top
	import duhmp_pkg::*;
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	// host bus pins
	input wire logic [2:0] regAddr,
	input wire logic chanASelect_n,
	input wire logic chanBSelect_n,
	input wire logic readStrobe_n,
	input wire logic writeStrobe_n,
	input wire logic [7:0] dataBusIn,
	output logic [7:0] dataBusOut,
	output logic dataBusOe,
	// modem lines
	input wire logic clearToSendA_n,
	input wire logic clearToSendB_n,
	output logic terminalReadyA_n,
	output logic terminalReadyB_n,
	// serial side hooks
	input wire logic [7:0] txChar,
	output logic [7:0] txShiftBits,
	output logic txAllowedA,
	output logic txAllowedB,
	output logic rs485DriveA,
	output logic rs485DriveB
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [4:0] pinMeta_reg;
	logic [4:0] pinSync_reg;
	logic [4:0] pinRaw;
	logic [7:0] busMeta_reg;
	logic [7:0] busSync_reg;
	logic [2:0] addrMeta_reg;
	logic [2:0] addrSync_reg;

	assign pinRaw = {clearToSendB_n, clearToSendA_n, chanBSelect_n, chanASelect_n, readStrobe_n};

	// two flops on every asynchronous pin; strobes reset to inactive high
	always_ff @(posedge clk) begin
		if (reset) begin
			pinMeta_reg <= 5'h1f;
			pinSync_reg <= 5'h1f;
			busMeta_reg <= 8'h00;
			busSync_reg <= 8'h00;
			addrMeta_reg <= 3'h0;
			addrSync_reg <= 3'h0;
		end else if (clkEn) begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
			busMeta_reg <= dataBusIn;
			busSync_reg <= busMeta_reg;
			addrMeta_reg <= regAddr;
			addrSync_reg <= addrMeta_reg;
		end
	end

	// write strobe synchroniser kept apart for edge detection
	logic wrMeta_reg;
	logic wrSync_reg;
	logic wrSyncDly_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			wrMeta_reg <= 1'b1;
			wrSync_reg <= 1'b1;
			wrSyncDly_reg <= 1'b1;
		end else if (clkEn) begin
			wrMeta_reg <= writeStrobe_n;
			wrSync_reg <= wrMeta_reg;
			wrSyncDly_reg <= wrSync_reg;
		end
	end

	logic readSync_n;
	logic selASync_n;
	logic selBSync_n;
	logic ctsASync_n;
	logic ctsBSync_n;
	assign readSync_n = pinSync_reg[0];
	assign selASync_n = pinSync_reg[1];
	assign selBSync_n = pinSync_reg[2];
	assign ctsASync_n = pinSync_reg[3];
	assign ctsBSync_n = pinSync_reg[4];

	// ************************************************************
	// access decode
	// ************************************************************
	duhmp_access_type access;
	logic writeFall;
	logic [NUM_CHANNELS-1:0] chanSel;
	assign chanSel = {~selBSync_n, ~selASync_n};
	// one store per strobe: take the falling edge of the write strobe
	assign writeFall = wrSyncDly_reg & ~wrSync_reg;

	// read wins over write if a host asserts both
	always_comb begin
		access = ACC_IDLE;
		if (chanSel == 2'b00) begin
			access = ACC_IDLE;
		end else if (!readSync_n) begin
			access = ACC_READ;
		end else if (writeFall) begin
			access = ACC_WRITE;
		end
	end

	// ************************************************************
	// channel register sets
	// ************************************************************
	logic [7:0] chanRead [NUM_CHANNELS];
	logic [7:0] chanMcr [NUM_CHANNELS];
	logic [7:0] chanEfr [NUM_CHANNELS];
	logic [NUM_CHANNELS-1:0] ctsSync_n;
	assign ctsSync_n = {ctsBSync_n, ctsASync_n};

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
			duhmp_chan_regs u_regs (
				.clk(clk),
				.reset(reset),
				.clkEn(clkEn),
				.writePulse((access == ACC_WRITE) && chanSel[ch]),
				.regAddr(addrSync_reg),
				.writeData(busSync_reg),
				.clearToSendSync(ctsSync_n[ch]),
				.readData_reg(chanRead[ch]),
				.modemControl_reg(chanMcr[ch]),
				.enhancedFeature_reg(chanEfr[ch])
			);
		end
	endgenerate

	// ************************************************************
	// data bus driver
	// ************************************************************
	// with both selects low channel a answers; the bus can carry only one
	// enable waits one extra edge so it never opens ahead of the read data register
	logic readPending_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			readPending_reg <= 1'b0;
		end else if (clkEn) begin
			readPending_reg <= (access == ACC_READ);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dataBusOut <= 8'h00;
			dataBusOe <= 1'b0;
		end else if (clkEn) begin
			dataBusOe <= readPending_reg && (access == ACC_READ);
			dataBusOut <= chanSel[0] ? chanRead[0] : chanRead[1];
		end
	end

	// ************************************************************
	// modem lines and flow control
	// ************************************************************
	// terminal ready is the inverted control bit, so reset gives high
	always_ff @(posedge clk) begin
		if (reset) begin
			terminalReadyA_n <= 1'b1;
			terminalReadyB_n <= 1'b1;
			txAllowedA <= 1'b1;
			txAllowedB <= 1'b1;
			rs485DriveA <= 1'b0;
			rs485DriveB <= 1'b0;
		end else if (clkEn) begin
			terminalReadyA_n <= ~chanMcr[0][MCR_TERMINAL_READY_BIT];
			terminalReadyB_n <= ~chanMcr[1][MCR_TERMINAL_READY_BIT];
			// pin only matters with auto flow on; otherwise always allowed
			txAllowedA <= ~chanEfr[0][EFR_AUTO_CTS_BIT] | ~ctsASync_n;
			txAllowedB <= ~chanEfr[1][EFR_AUTO_CTS_BIT] | ~ctsBSync_n;
			// rs-485 direction follows the same control bit as terminal ready
			rs485DriveA <= chanEfr[0][EFR_RS485_BIT] & chanMcr[0][MCR_TERMINAL_READY_BIT];
			rs485DriveB <= chanEfr[1][EFR_RS485_BIT] & chanMcr[1][MCR_TERMINAL_READY_BIT];
		end
	end

	// serial order: element 0 leaves the shifter first and is bus bit 0
	always_ff @(posedge clk) begin
		if (reset) begin
			txShiftBits <= 8'h00;
		end else if (clkEn) begin
			txShiftBits <= txChar;
		end
	end
endmodule // duhmp_top
